// ===== rtl/rgbp_params.svh
// constants for the rgb panel sync interface: offsets, resets, counts
// assumes inclusion by bare name from the panel module and the test bench
`ifndef RGBP_PARAMS_SVH
`define RGBP_PARAMS_SVH
`define RGBP_IDX_LINE_BP    8'h16
`define RGBP_IDX_FRAME_BP   8'h17
`define RGBP_IDX_MODE       8'h18
`define RGBP_IDX_PARTIAL    8'h19
`define RGBP_RST_LINE_BP    6'h06
`define RGBP_RST_FRAME_BP   9'h002
`define RGBP_RST_PART_BP    8'h00
`define RGBP_RST_PART_LINES 8'hF0
`define RGBP_LINE_BP_BASE   10'h002
`define RGBP_MAX_FRAME_BP   9'h140
`define RGBP_MAX_PART_BP    8'hEF
`define RGBP_MAX_PART_LINES 8'hF0
`define RGBP_WAKE_FRAMES    4'hA
`define RGBP_OFF_FRAMES     4'h2
`define RGBP_WORD_BITS      4'h9
`endif

// ===== rtl/rgbp_pkg.sv
// types shared by the rgb panel sync interface
// assumes rgbp_params.svh is on the include path
package rgbp_pkg;
   typedef struct packed {
      logic [5:0] line_back_porch;
      logic [8:0] frame_back_porch;
      logic       eight_colour;
      logic [7:0] partial_back_porch;
      logic [7:0] partial_active_lines;
   } rgbp_cfg_s;
   typedef struct packed {
      logic [5:0] red;
      logic [5:0] green;
      logic [5:0] blue;
   } rgbp_pix_s;
   typedef enum logic [1:0] {ST_SLEEP, ST_WAKE, ST_ON, ST_DOWN} rgbp_st_e;
endpackage

// ===== rtl/rgbp_panel.sv
// rgb panel input side: serial config port on mclk, pixel path on dot clock
// assumes host keeps dot clock running and sync timing within limits
//
// How it works
// R1: host must supply dot clock always
// R2: host keeps line/frame sync skew bounded
// R3: typical line: 8+320+8 dot clocks
// R4: typical frame: 2+240+2 lines
// R5: host holds reset at least ten microseconds
// R6: eight-colour uses msbs, zero outside range
// R7: partial porch 0..239, active 1..240
// R8: host toggles sleep no faster than 12 frames
// R9: dot clock runs on after power-on
// R10: host waits 1us before sleep release
// R11: dot clock starts before sleep release
// R12: image on at tenth frame sync fall
// R13: image off at second frame sync fall
// R14: host keeps syncs two frames after sleep
// R15: host resets only after two-frame shutdown
// R16: select low frames serial transfer
// R17: flag bit picks index or data word
// R18: six-bit channels, zero black, msb bit 5
// R19: line porch n gives n+2 dummy clocks
// R20: frame porch lines counted as dummy
// R21: sample on rising dot edge, count xy
// R22: flag first, then payload msb first
`include "rgbp_params.svh"
`timescale 1ns/100ps
`default_nettype none
module rgbp_panel #(
   parameter int H_ACTIVE = 320,
   parameter int V_ACTIVE = 240
) (
   input  wire logic              mclk_in,
   input  wire logic              rst_in,
   input  wire logic              panel_reset_n_in,
   input  wire logic              serial_select_n_in,
   input  wire logic              serial_clk_in,
   input  wire logic              serial_data_in,
   input  wire logic              dot_clk_in,
   input  wire logic              frame_sync_n_in,
   input  wire logic              line_sync_n_in,
   input  wire logic              sleep_in,
   input  wire rgbp_pkg::rgbp_pix_s pix_in,
   output var  rgbp_pkg::rgbp_pix_s pix_out,
   output logic                   pix_valid_out,
   output logic [8:0]             pix_x_out,
   output logic [7:0]             pix_y_out,
   output logic                   display_on_out
);
   if (H_ACTIVE < 1 || H_ACTIVE > 320 || V_ACTIVE < 1 || V_ACTIVE > 240) begin
      $error("rgbp_panel: active size out of range");
   end
   // ---------------- mclk side: reset and serial port ----------------
   logic [1:0] rstn_sync, cs_sync, sck_sync, sdi_sync;
   logic       sck_prev, sys_rst, dot_rst;
   always_ff @(posedge mclk_in) begin
      rstn_sync <= {rstn_sync[0], panel_reset_n_in};
      cs_sync   <= {cs_sync[0], serial_select_n_in};
      sck_sync  <= {sck_sync[0], serial_clk_in};
      sdi_sync  <= {sdi_sync[0], serial_data_in};
      sck_prev  <= sck_sync[1];
   end
   assign sys_rst = rst_in | ~rstn_sync[1];
   logic [3:0]  bit_cnt, next_bit_cnt;
   logic [8:0]  shreg, next_shreg;
   logic [7:0]  index, next_index, hi_byte, next_hi_byte;
   logic        half, next_half, upd_tgl, next_upd_tgl;
   rgbp_pkg::rgbp_cfg_s cfg_m, next_cfg_m;
   logic        sck_rise, word_done;
   logic [15:0] wdata;
   // serial clock is oversampled on mclk: sck must stay under mclk/4
   assign sck_rise  = sck_sync[1] & ~sck_prev & ~cs_sync[1]; // R16
   assign word_done = sck_rise && bit_cnt == `RGBP_WORD_BITS - 4'h1;
   assign wdata     = {hi_byte, shreg[6:0], sdi_sync[1]};
   always_comb begin
      next_bit_cnt = bit_cnt;
      next_shreg   = shreg;
      next_index   = index;
      next_hi_byte = hi_byte;
      next_half    = half;
      next_upd_tgl = upd_tgl;
      next_cfg_m   = cfg_m;
      if (cs_sync[1]) begin
         next_bit_cnt = 4'h0; // R16
      end else if (sck_rise) begin
         next_shreg   = {shreg[7:0], sdi_sync[1]}; // R22
         next_bit_cnt = word_done ? 4'h0 : bit_cnt + 4'h1;
      end
      if (word_done) begin
         if (!shreg[7]) begin // R17
            next_index = {shreg[6:0], sdi_sync[1]};
            next_half  = 1'b0;
         end else if (!half) begin
            next_hi_byte = {shreg[6:0], sdi_sync[1]};
            next_half    = 1'b1;
         end else begin
            next_half    = 1'b0;
            next_upd_tgl = ~upd_tgl;
            unique case (index)
               `RGBP_IDX_LINE_BP:
                  next_cfg_m.line_back_porch = wdata[5:0];
               `RGBP_IDX_FRAME_BP:
                  if (wdata[8:0] <= `RGBP_MAX_FRAME_BP) begin // R20
                     next_cfg_m.frame_back_porch = wdata[8:0];
                  end
               `RGBP_IDX_MODE:
                  next_cfg_m.eight_colour = wdata[0];
               `RGBP_IDX_PARTIAL:
                  if (wdata[15:8] <= `RGBP_MAX_PART_BP && wdata[7:0] != 8'h00
                      && wdata[7:0] <= `RGBP_MAX_PART_LINES) begin // R7
                     next_cfg_m.partial_back_porch   = wdata[15:8];
                     next_cfg_m.partial_active_lines = wdata[7:0];
                  end
               default: next_upd_tgl = upd_tgl;
            endcase
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst) begin
         bit_cnt <= 4'h0;
         shreg   <= 9'h000;
         index   <= 8'h00;
         hi_byte <= 8'h00;
         half    <= 1'b0;
         upd_tgl <= 1'b0;
         cfg_m   <= '{`RGBP_RST_LINE_BP, `RGBP_RST_FRAME_BP, 1'b0,
                      `RGBP_RST_PART_BP, `RGBP_RST_PART_LINES};
      end else begin
         bit_cnt <= next_bit_cnt;
         shreg   <= next_shreg;
         index   <= next_index;
         hi_byte <= next_hi_byte;
         half    <= next_half;
         upd_tgl <= next_upd_tgl;
         cfg_m   <= next_cfg_m;
      end
   end

   // ---------------- dot clock side ----------------
   // config crosses by toggle: cfg_m holds still for many dot clocks
   logic [1:0] drst_sync, sleep_sync;
   logic [2:0] tgl_sync;
   always_ff @(posedge dot_clk_in) begin
      drst_sync  <= {drst_sync[0], sys_rst};
      sleep_sync <= {sleep_sync[0], sleep_in};
      tgl_sync   <= {tgl_sync[1:0], upd_tgl};
   end
   assign dot_rst = drst_sync[1];
   rgbp_pkg::rgbp_cfg_s cfg_p, next_cfg_p;
   rgbp_pkg::rgbp_st_e  st, next_st;
   rgbp_pkg::rgbp_pix_s next_pix;
   logic [9:0] pcnt, next_pcnt, lcnt, next_lcnt;
   logic [9:0] x_first, x_last, y_first, y_last, xi, yi;
   logic [3:0] frm_cnt, next_frm_cnt;
   logic       vs_prev, hs_prev, vs_fall, hs_fall, disp_on;
   logic       next_valid, in_part;
   logic [8:0] next_x;
   logic [7:0] next_y;
   assign vs_fall = vs_prev & ~frame_sync_n_in; // R21
   assign hs_fall = hs_prev & ~line_sync_n_in;  // R21
   assign disp_on = st == rgbp_pkg::ST_ON || st == rgbp_pkg::ST_DOWN; // R13
   assign x_first = {4'h0, cfg_p.line_back_porch} + `RGBP_LINE_BP_BASE; // R19
   assign x_last  = x_first + 10'(H_ACTIVE);
   assign y_first = {1'b0, cfg_p.frame_back_porch} + 10'h001; // R20
   assign y_last  = y_first + 10'(V_ACTIVE);
   assign xi      = pcnt - x_first;
   assign yi      = lcnt - y_first;
   assign in_part = yi[7:0] >= cfg_p.partial_back_porch &&
                    {2'b00, yi[7:0]} < {2'b00, cfg_p.partial_back_porch}
                    + {2'b00, cfg_p.partial_active_lines};
   always_comb begin
      next_cfg_p   = (tgl_sync[2] != tgl_sync[1]) ? cfg_m : cfg_p;
      next_pcnt    = hs_fall ? 10'h001 : (pcnt == 10'h3FF ? pcnt : pcnt + 10'h1);
      next_lcnt    = vs_fall ? 10'h000 : lcnt;
      if (hs_fall && lcnt != 10'h3FF) begin
         next_lcnt = next_lcnt + 10'h1;
      end
      next_valid   = !hs_fall && pcnt >= x_first && pcnt < x_last &&
                     lcnt >= y_first && lcnt < y_last; // R19 R20
      next_x       = xi[8:0];
      next_y       = yi[7:0];
      next_pix     = pix_in; // R18
      if (cfg_p.eight_colour) begin // R6
         next_pix.red   = in_part ? {6{pix_in.red[5]}}   : 6'h00;
         next_pix.green = in_part ? {6{pix_in.green[5]}} : 6'h00;
         next_pix.blue  = in_part ? {6{pix_in.blue[5]}}  : 6'h00;
      end
      if (!disp_on || !next_valid) begin
         next_pix = '0;
      end
      next_st      = st;
      next_frm_cnt = frm_cnt;
      unique case (st)
         rgbp_pkg::ST_SLEEP: if (!sleep_sync[1]) begin
            next_st      = rgbp_pkg::ST_WAKE;
            next_frm_cnt = 4'h0;
         end
         rgbp_pkg::ST_WAKE: if (sleep_sync[1]) begin
            next_st = rgbp_pkg::ST_SLEEP;
         end else if (vs_fall) begin // R12
            next_frm_cnt = frm_cnt + 4'h1;
            if (frm_cnt == `RGBP_WAKE_FRAMES - 4'h1) begin
               next_st = rgbp_pkg::ST_ON;
            end
         end
         rgbp_pkg::ST_ON: if (sleep_sync[1]) begin
            next_st      = rgbp_pkg::ST_DOWN;
            next_frm_cnt = 4'h0;
         end
         rgbp_pkg::ST_DOWN: if (vs_fall) begin // R13
            next_frm_cnt = frm_cnt + 4'h1;
            if (frm_cnt == `RGBP_OFF_FRAMES - 4'h1) begin
               next_st = rgbp_pkg::ST_SLEEP;
            end
         end
      endcase
   end

   always_ff @(posedge dot_clk_in) begin
      if (dot_rst) begin
         cfg_p          <= '{`RGBP_RST_LINE_BP, `RGBP_RST_FRAME_BP, 1'b0,
                             `RGBP_RST_PART_BP, `RGBP_RST_PART_LINES};
         st             <= rgbp_pkg::ST_SLEEP;
         frm_cnt        <= 4'h0;
         pcnt           <= 10'h3FF;
         lcnt           <= 10'h3FF;
         vs_prev        <= 1'b1;
         hs_prev        <= 1'b1;
         pix_out        <= '0;
         pix_valid_out  <= 1'b0;
         pix_x_out      <= 9'h000;
         pix_y_out      <= 8'h00;
         display_on_out <= 1'b0;
      end else begin
         cfg_p          <= next_cfg_p;
         st             <= next_st;
         frm_cnt        <= next_frm_cnt;
         pcnt           <= next_pcnt;
         lcnt           <= next_lcnt;
         vs_prev        <= frame_sync_n_in;
         hs_prev        <= line_sync_n_in;
         pix_out        <= next_pix;
         pix_valid_out  <= next_valid & disp_on;
         pix_x_out      <= next_x;
         pix_y_out      <= next_y;
         display_on_out <= disp_on;
      end
   end
   a_blank_off: assert property (@(posedge dot_clk_in) // R13
      disable iff (dot_rst) !disp_on |=> pix_out == '0 && !pix_valid_out)
      else $error("pixel data while display off");
   a_wake_tenth: assert property (@(posedge dot_clk_in) // R12
      disable iff (dot_rst) $rose(display_on_out) |->
      $past(frm_cnt, 2) == `RGBP_WAKE_FRAMES - 4'h1)
      else $error("display on not at tenth frame fall");
   a_off_second: assert property (@(posedge dot_clk_in) // R13
      disable iff (dot_rst) $past(st) == rgbp_pkg::ST_DOWN && !disp_on |->
      $past(frm_cnt) == `RGBP_OFF_FRAMES - 4'h1 && $past(vs_fall))
      else $error("display off not at second frame fall");
   a_eight_msb: assert property (@(posedge dot_clk_in) // R6
      disable iff (dot_rst) pix_valid_out && $past(cfg_p.eight_colour) |->
      pix_out.red inside {6'h00, 6'h3F} && pix_out.blue inside {6'h00, 6'h3F})
      else $error("eight-colour pixel not msb only");
   a_first_pixel: assert property (@(posedge dot_clk_in) // R19
      disable iff (dot_rst) pix_valid_out |->
      $past(pcnt) >= $past(x_first) && pix_x_out < 9'(H_ACTIVE))
      else $error("pixel taken inside line porch");
   a_line_window: assert property (@(posedge dot_clk_in) // R20
      disable iff (dot_rst) pix_valid_out |-> pix_y_out < 8'(V_ACTIVE) &&
      $past(lcnt) > {1'b0, $past(cfg_p.frame_back_porch)})
      else $error("pixel taken inside frame porch");
   a_part_zero: assert property (@(posedge dot_clk_in) // R6
      disable iff (dot_rst) pix_valid_out && $past(cfg_p.eight_colour) &&
      !$past(in_part) |-> pix_out == '0)
      else $error("data outside partial range");
   a_serial_write: assert property (@(posedge mclk_in) // R17
      disable iff (sys_rst) word_done && shreg[7] && half && index ==
      `RGBP_IDX_LINE_BP |=> !half &&
      cfg_m.line_back_porch == $past(wdata[5:0]))
      else $error("line porch write lost");
   a_select_idle: assert property (@(posedge mclk_in) // R16
      disable iff (sys_rst) cs_sync[1] |=> bit_cnt == 4'h0)
      else $error("bits counted with select high");
   a_part_range: assert property (@(posedge mclk_in) // R7
      disable iff (sys_rst) cfg_m.partial_active_lines != 8'h00 &&
      cfg_m.partial_back_porch <= `RGBP_MAX_PART_BP)
      else $error("partial range out of bounds");
   c_wake: cover property (@(posedge dot_clk_in) $rose(display_on_out));
   c_sleep: cover property (@(posedge dot_clk_in) $fell(display_on_out));
   c_eight_pix: cover property (@(posedge dot_clk_in)
      pix_valid_out && cfg_p.eight_colour);
   c_write: cover property (@(posedge mclk_in) word_done && half);
endmodule
`default_nettype wire

// ===== verification/rgbp_host_model.sv
// host controller model: drives the pixel link and the serial config port
// assumes the bench makes both clocks; dot clock runs free
`timescale 1ns/100ps
`default_nettype none
module rgbp_host_model #(
   parameter int H = 8,
   parameter int V = 4
) (
   input  wire logic               mclk_in,
   input  wire logic               dot_clk_in,
   output logic                    sel_n_out,
   output logic                    sclk_out,
   output logic                    sdata_out,
   output logic                    fsync_n_out,
   output logic                    lsync_n_out,
   output var rgbp_pkg::rgbp_pix_s pix_out
);
   initial begin
      sel_n_out = 1'b1;
      sclk_out = 1'b0;
      sdata_out = 1'b0;
      fsync_n_out = 1'b1;
      lsync_n_out = 1'b1;
      pix_out = '0;
   end
   // released data line shows junk, not its last bit
   always @(posedge mclk_in)
      if (sel_n_out)
         sdata_out <= ~sdata_out;
   function automatic rgbp_pkg::rgbp_pix_s pat(input int x, input int y);
      pat.red = {x[0], 5'h15};
      pat.green = {y[0], 5'h0A};
      pat.blue = {~x[0], x[4:0]};
   endfunction
   // flag first, payload msb first; oversampled, so 4 mclk per phase
   task automatic send_bits(input logic [8:0] w, input int n);
      @(posedge mclk_in);
      sel_n_out <= 1'b0;
      for (int b = 8; b > 8 - n; b--) begin
         @(posedge mclk_in);
         sclk_out <= 1'b0;
         sdata_out <= w[b];
         repeat (4) @(posedge mclk_in);
         sclk_out <= 1'b1;
         repeat (3) @(posedge mclk_in);
      end
   endtask
   task automatic end_xfer;
      @(posedge mclk_in);
      sclk_out <= 1'b0;
      repeat (4) @(posedge mclk_in);
      sel_n_out <= 1'b1;
      repeat (10) @(posedge mclk_in);
   endtask
   task automatic write_reg(input logic [7:0] idx, input logic [15:0] d);
      send_bits({1'b0, idx}, 9);
      send_bits({1'b1, d[15:8]}, 9);
      send_bits({1'b1, d[7:0]}, 9);
      end_xfer();
   endtask
   // frame sync falls well clear of the first line sync
   task automatic frame(input int ds, input int vs);
      for (int i = 0; i < 4; i++) begin
         @(posedge dot_clk_in);
         fsync_n_out <= !(i == 1 || i == 2);
         pix_out <= ~pix_out;
      end
      for (int l = 0; l < vs + V + 2; l++)
         for (int i = 0; i < ds + H + 8; i++) begin
            @(posedge dot_clk_in);
            lsync_n_out <= (i >= 2);
            if (i >= ds && i < ds + H && l >= vs && l < vs + V)
               pix_out <= pat(i - ds, l - vs);
            else
               pix_out <= ~pix_out;
         end
   endtask
endmodule
`default_nettype wire

// ===== verification/rgbp_panel_test.sv
// self-checking bench for the rgb panel input side
// assumes rgbp_params.svh on the include path; small active area
`include "rgbp_params.svh"
`timescale 1ns/100ps
`default_nettype none
module rgbp_panel_test;
   localparam int H = 8;
   localparam int V = 4;
   logic                mclk, dot, rst, sleep, prst_n, eight;
   logic                sel_n, sclk, sdata, fs_n, ls_n, vld, on;
   rgbp_pkg::rgbp_pix_s pix_h, pix_o;
   logic [8:0]          px;
   logic [7:0]          py;
   int                  n_errors, n_tests, n_pix, ex, ey, pbp, pl;
   rgbp_panel #(.H_ACTIVE(H), .V_ACTIVE(V)) i_dut (
      .mclk_in(mclk), .rst_in(rst), .panel_reset_n_in(prst_n),
      .serial_select_n_in(sel_n), .serial_clk_in(sclk),
      .serial_data_in(sdata), .dot_clk_in(dot), .frame_sync_n_in(fs_n),
      .line_sync_n_in(ls_n), .sleep_in(sleep), .pix_in(pix_h),
      .pix_out(pix_o), .pix_valid_out(vld), .pix_x_out(px),
      .pix_y_out(py), .display_on_out(on));
   rgbp_host_model #(.H(H), .V(V)) i_host (
      .mclk_in(mclk), .dot_clk_in(dot), .sel_n_out(sel_n),
      .sclk_out(sclk), .sdata_out(sdata), .fsync_n_out(fs_n),
      .lsync_n_out(ls_n), .pix_out(pix_h));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // dot clock free-running, phase unrelated to mclk
   initial begin
      dot = 1'b0;
      #7;
      forever #16 dot = ~dot;
   end
   task automatic chk_val(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
         n_errors++;
      end
   endtask
   task automatic chk_pix(input string nm, input rgbp_pkg::rgbp_pix_s e, g);
      n_tests++;
      if (g !== e) begin
         $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
         n_errors++;
      end
   endtask
   function automatic rgbp_pkg::rgbp_pix_s exp_pix(input int x, y);
      exp_pix = i_host.pat(x, y);
      if (eight && (y < pbp || y >= pbp + pl))
         exp_pix = '0;
      else if (eight)
         exp_pix = {{6{exp_pix.red[5]}}, {6{exp_pix.green[5]}},
                    {6{exp_pix.blue[5]}}};
   endfunction
   always @(posedge dot)
      if (vld === 1'b1) begin
         chk_val("column", ex, {23'h0, px});
         chk_val("row", ey, {24'h0, py});
         chk_pix("pixel", exp_pix(ex, ey), pix_o);
         n_pix++;
         ex = (ex == H - 1) ? 0 : ex + 1;
         ey = (ex == 0) ? ey + 1 : ey;
      end
   task automatic frame(input int ds, vs, n);
      ex = 0;
      ey = 0;
      n_pix = 0;
      i_host.frame(ds, vs);
      chk_val("pixel count", n, n_pix);
   endtask
   task automatic t_wake;
      @(posedge mclk);
      sleep <= 1'b0;
      repeat (6) @(posedge dot);
      for (int f = 1; f <= 10; f++) begin
         frame(8, 2, (f == 10) ? H * V : 0);
         chk_val("display on", f == 10, on);
      end
      $display("test wake done");
   endtask
   task automatic t_porch;
      int t [3][2] = '{'{0, 1}, '{63, 320}, '{6, 2}};
      for (int k = 0; k < 3; k++) begin
         i_host.write_reg(`RGBP_IDX_LINE_BP, 16'(t[k][0]));
         i_host.write_reg(`RGBP_IDX_FRAME_BP, 16'(t[k][1]));
         frame(t[k][0] + 2, t[k][1], H * V);
      end
      $display("test porch done");
   endtask
   task automatic t_refuse;
      i_host.send_bits(9'h1FF, 4);
      i_host.end_xfer();
      // a lone data word must be dropped by the next index word
      i_host.send_bits(9'h100, 9);
      i_host.end_xfer();
      i_host.write_reg(`RGBP_IDX_FRAME_BP, 16'h0001);
      // unknown index: no setting may change
      i_host.write_reg(8'h20, 16'h0000);
      frame(8, 1, H * V);
      i_host.write_reg(`RGBP_IDX_FRAME_BP, 16'h0141);
      frame(8, 1, H * V);
      i_host.write_reg(`RGBP_IDX_FRAME_BP, 16'h0002);
      $display("test refuse done");
   endtask
   task automatic t_eight;
      i_host.write_reg(`RGBP_IDX_MODE, 16'h0001);
      i_host.write_reg(`RGBP_IDX_PARTIAL, 16'h0102);
      eight = 1'b1;
      pbp = 1;
      pl = 2;
      frame(8, 2, H * V);
      i_host.write_reg(`RGBP_IDX_PARTIAL, 16'h0100);
      frame(8, 2, H * V);
      i_host.write_reg(`RGBP_IDX_MODE, 16'h0000);
      eight = 1'b0;
      $display("test eight colour done");
   endtask
   task automatic t_sleep;
      @(posedge mclk);
      sleep <= 1'b1;
      repeat (6) @(posedge dot);
      frame(8, 2, H * V);
      chk_val("display on", 1, on);
      frame(8, 2, 0);
      chk_val("display on", 0, on);
      $display("test sleep done");
   endtask
   // pin reset must restore the default line porch
   task automatic t_pin;
      i_host.write_reg(`RGBP_IDX_LINE_BP, 16'h0000);
      for (int f = 0; f < 10; f++)
         frame(8, 2, 0);
      prst_n <= 1'b0;
      repeat (100) @(posedge mclk);
      prst_n <= 1'b1;
      repeat (5) @(posedge mclk);
      chk_val("display on", 0, on);
      t_wake();
      $display("test pin reset done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge mclk);
      n_errors++;
      wrap_up();
   end
   initial begin
      {rst, sleep, prst_n, eight} = 4'hE;
      {n_errors, n_tests, pbp, pl} = '0;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      chk_val("display on", 0, on);
      chk_val("valid", 0, vld);
      t_wake();
      t_porch();
      t_refuse();
      t_eight();
      t_sleep();
      t_pin();
      wrap_up();
   end
endmodule
`default_nettype wire
